// *** maintenance_hours_counter_bench.sv ***
// self-checking bench for the maintenance hours counter
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module maintenance_hours_counter_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat_w = 32'h00000000;
    logic [31:0] dat_r;
    logic [31:0] q;
    logic [31:0] ot;
    logic        ack;
    logic        alarm;
    logic        irq;
    logic        run = 1'b0;
    logic        rcmd = 1'b0;
    logic        acmd = 1'b0;
    logic [13:0] hrs = 14'h0000;
    logic        en;
    logic        ir;
    logic        fr;
    logic [13:0] ext;
    int          fails = 0;
    int          n_compared = 0;
    int          cycles = 0;
    always #25 clk = ~clk;
    mhc_counter #(.TICK_CYCLES(4)) u_mhc_counter (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat_w),
        .wb_dat_o(dat_r), .wb_ack_o(ack), .enable_i(en), .interval_reset_i(ir),
        .full_reset_i(fr), .ext_interval_h_i(ext), .alarm_o(alarm), .irq_o(irq));
    mhc_field u_mhc_field (.clk_i(clk), .run_i(run), .rst_cmd_i(rcmd), .all_cmd_i(acmd),
        .hours_i(hrs), .enable_o(en), .interval_reset_o(ir), .full_reset_o(fr),
        .ext_interval_h_o(ext));
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            fails++;
            $display("[FAIL] timeout expected %0d seen %0d", 20000, cycles);
            stop_test();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step
    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 100);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (k >= 100) begin
            fails++;
            $display("[FAIL] ack expected 1 seen %b", ack);
        end
    endtask : wb
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
        wb(1'b0, a, 32'h0);
        `CHK(nm, e, q)
    endtask : rd_chk
    task automatic wait_alarm(input logic v);
        int k;
        k = 0;
        while (alarm !== v && k < 200) begin
            @(posedge clk);
            k++;
        end
        `CHK("alarm", v, alarm)
    endtask : wait_alarm
    initial begin
        step(3);
        rst <= 1'b0;
        rd_chk(mhc_pkg::ADR_CTRL, 32'h0, "ctrl");
        rd_chk(mhc_pkg::ADR_IRQ_MASK, 32'h0, "mask");
        `CHK("alarm power-up", 1'b1, alarm)
        rd_chk(mhc_pkg::ADR_IRQ_ST, 32'h1, "irq_st");
        wb(1'b1, mhc_pkg::ADR_IRQ_ST, 32'h1);
        rd_chk(mhc_pkg::ADR_IRQ_ST, 32'h0, "irq_st clr");
        wb(1'b1, 8'h1c, 32'hffffffff);
        rd_chk(8'h1c, 32'h0, "unmapped");
        wb(1'b1, mhc_pkg::ADR_INTERVAL, 32'h003fff3f);
        rd_chk(mhc_pkg::ADR_INTERVAL, 32'h00270f3b, "interval clamp");
        wb(1'b1, mhc_pkg::ADR_INTERVAL, 32'h00000002);
        rd_chk(mhc_pkg::ADR_REMAIN, 32'h00000002, "remain reload");
        acmd <= 1'b1;
        step(2);
        acmd <= 1'b0;
        step(6);
        rd_chk(mhc_pkg::ADR_OPTIME, 32'h0, "optime cleared");
        rd_chk(mhc_pkg::ADR_REMAIN, 32'h2, "remain full");
        wb(1'b1, mhc_pkg::ADR_IRQ_MASK, 32'h3);
        step(1);
        `CHK("irq idle", 1'b0, irq)
        run <= 1'b1;
        wait_alarm(1'b1);
        run <= 1'b0;
        step(8);
        `CHK("alarm kept", 1'b1, alarm)
        rd_chk(mhc_pkg::ADR_REMAIN, 32'h0, "remain zero");
        `CHK("irq", 1'b1, irq)
        wb(1'b1, mhc_pkg::ADR_IRQ_ST, 32'h1);
        step(1);
        `CHK("irq clr", 1'b0, irq)
        wb(1'b0, mhc_pkg::ADR_OPTIME, 32'h0);
        ot = q;
        step(10);
        rd_chk(mhc_pkg::ADR_OPTIME, ot, "optime idle");
        rcmd <= 1'b1;
        step(2);
        rcmd <= 1'b0;
        step(6);
        `CHK("alarm ir", 1'b0, alarm)
        rd_chk(mhc_pkg::ADR_REMAIN, 32'h2, "remain ir");
        rd_chk(mhc_pkg::ADR_OPTIME, ot, "optime ir");
        rcmd <= 1'b1;
        run <= 1'b1;
        step(40);
        `CHK("alarm held", 1'b0, alarm)
        wb(1'b0, mhc_pkg::ADR_OPTIME, 32'h0);
        `CHK("optime grows", 1'b1, q > ot)
        rcmd <= 1'b0;
        wait_alarm(1'b1);
        wb(1'b1, mhc_pkg::ADR_CTRL, 32'h1);
        run <= 1'b0;
        wait_alarm(1'b0);
        wb(1'b1, mhc_pkg::ADR_CTRL, 32'h2);
        wb(1'b1, mhc_pkg::ADR_INTERVAL, 32'h00001e00);
        wb(1'b1, mhc_pkg::ADR_OPTIME, 32'h00006400);
        step(3);
        rd_chk(mhc_pkg::ADR_REMAIN, 32'h00001400, "remain preset");
        wb(1'b1, mhc_pkg::ADR_CTRL, 32'h0);
        wb(1'b1, mhc_pkg::ADR_OPTIME, 32'h00000500);
        rd_chk(mhc_pkg::ADR_OPTIME, 32'h00006400, "optime run");
        wb(1'b1, mhc_pkg::ADR_INTERVAL, 32'h00000c00);
        step(2);
        rd_chk(mhc_pkg::ADR_REMAIN, 32'h00000c00, "remain change");
        rst <= 1'b1;
        step(2);
        rst <= 1'b0;
        rd_chk(mhc_pkg::ADR_INTERVAL, 32'h00000c00, "interval kept");
        rd_chk(mhc_pkg::ADR_OPTIME, 32'h00006400, "optime kept");
        rd_chk(mhc_pkg::ADR_REMAIN, 32'h00000c00, "remain kept");
        wb(1'b1, mhc_pkg::ADR_CTRL, 32'h2);
        wb(1'b1, mhc_pkg::ADR_OPTIME, 32'h01869e3b);
        wb(1'b1, mhc_pkg::ADR_CTRL, 32'h0);
        wb(1'b1, mhc_pkg::ADR_IRQ_MASK, 32'h2);
        run <= 1'b1;
        step(300);
        run <= 1'b0;
        step(4);
        wb(1'b0, mhc_pkg::ADR_OPTIME, 32'h0);
        `CHK("optime sat", 17'h1869f, q[24:8])
        wb(1'b0, mhc_pkg::ADR_STATUS, 32'h0);
        `CHK("sat flag", 1'b1, q[mhc_pkg::ST_SAT])
        `CHK("irq sat", 1'b1, irq)
        hrs <= 14'h0007;
        wb(1'b1, mhc_pkg::ADR_CTRL, 32'h4);
        step(4);
        rd_chk(mhc_pkg::ADR_REMAIN, 32'h00000700, "remain ext");
        stop_test();
    end
endmodule : maintenance_hours_counter_bench

// *** mhc_counter.sv ***
// maintenance hours counter core with wishbone registers
//
// The placing of the registers and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - interval reset edge clears alarm, reloads remaining
// - full reset edge clears alarm, operating time
// - count time only while enable is high
// - alarm set when remaining reaches zero
// - reset-only mode: resets hold alarm low
// - idle mode: resets or idle enable clear
// - interval, remaining, operating time survive reset
// - interval limited to 9999 h 59 m
// - operating time saturates at 99999 hours
// - interval reset leaves operating time alone
// - counting continues whatever interval reset level
// - programming preset: remaining = interval - ot%interval
// - run mode: no preset; interval change reloads
module mhc_counter #(
    parameter int unsigned TICK_CYCLES = mhc_pkg::MINUTE_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        enable_i,
    input  wire logic        interval_reset_i,
    input  wire logic        full_reset_i,
    input  wire logic [13:0] ext_interval_h_i,
    output logic             alarm_o,
    output logic             irq_o
);
    localparam int MW = mhc_pkg::MIN_W;
    localparam int HL = mhc_pkg::HOUR_LSB;

    function automatic logic [22:0] to_min(input logic [16:0] h, input logic [5:0] m);
        return 23'(h) * mhc_pkg::MIN_PER_H + 23'(m);
    endfunction : to_min

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic [5:0] clamp_m(input logic [5:0] m);
        return (m > mhc_pkg::MIN_MAX) ? mhc_pkg::MIN_MAX : m;
    endfunction : clamp_m

    // pin synchronisers and edge history
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] prev;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            prev  <= 3'h0;
        end else begin
            sync1 <= {full_reset_i, interval_reset_i, enable_i};
            sync2 <= sync1;
            prev  <= sync2;
        end
    end
    wire en_s    = sync2[0];
    wire ir_s    = sync2[1];
    wire fr_s    = sync2[2];
    wire ir_rise = sync2[1] & ~prev[1];
    wire fr_rise = sync2[2] & ~prev[2];

    // control and interrupt state
    logic [2:0] ctrl;
    logic [1:0] irq_st;
    logic [1:0] irq_mask;
    logic       recalc;
    logic       alarm;
    logic       ack_q;
    wire        idle_clr = ctrl[mhc_pkg::CTRL_IDLE_CLR];
    wire        prog     = ctrl[mhc_pkg::CTRL_PROG];
    wire        ext_sel  = ctrl[mhc_pkg::CTRL_EXT_SEL];

    // retained counters: no reset, rst_i leaves them alone; they power up at zero
    logic [13:0] mi_h = 14'h0;
    logic [5:0]  mi_m = 6'h0;
    logic [13:0] rem_h = 14'h0;
    logic [5:0]  rem_m = 6'h0;
    logic [16:0] ot_h = 17'h0;
    logic [5:0]  ot_m = 6'h0;
    logic [19:0] mi_seen = 20'h0;

    // bus decode
    wire        req   = wb_cyc_i & wb_stb_i;
    wire        wr    = req & wb_we_i & ack_q;
    wire        wr_ct = wr & (wb_adr_i == mhc_pkg::ADR_CTRL);
    wire        wr_mi = wr & (wb_adr_i == mhc_pkg::ADR_INTERVAL);
    wire        wr_ot = wr & (wb_adr_i == mhc_pkg::ADR_OPTIME) & prog;
    wire        wr_is = wr & (wb_adr_i == mhc_pkg::ADR_IRQ_ST);
    wire        wr_im = wr & (wb_adr_i == mhc_pkg::ADR_IRQ_MASK);
    wire [31:0] mi_rd = {10'h0, mi_h, 2'h0, mi_m};
    wire [31:0] ot_rd = {7'h0, ot_h, 2'h0, ot_m};
    wire [31:0] mi_wd = merge(mi_rd, wb_dat_i, wb_sel_i);
    wire [31:0] ot_wd = merge(ot_rd, wb_dat_i, wb_sel_i);
    wire [31:0] ct_wd = merge({29'h0, ctrl}, wb_dat_i, wb_sel_i);
    wire [31:0] is_wd = merge(32'h0, wb_dat_i, wb_sel_i);
    wire [31:0] im_wd = merge({30'h0, irq_mask}, wb_dat_i, wb_sel_i);

    // effective interval: own register or an external value in hours
    wire [13:0] ext_h  = (ext_interval_h_i > mhc_pkg::MI_H_MAX) ? mhc_pkg::MI_H_MAX
                                                                : ext_interval_h_i;
    wire [13:0] eff_h  = ext_sel ? ext_h : mi_h;
    wire [5:0]  eff_m  = ext_sel ? 6'h0 : mi_m;
    wire [19:0] eff_mi = {eff_h, eff_m};
    wire        mi_chg = (eff_mi != mi_seen);

    // preset recalculation from operating time
    wire [22:0] mi_t  = to_min(17'(eff_h), eff_m);
    wire [22:0] ot_t  = to_min(ot_h, ot_m);
    wire [22:0] r_t   = (mi_t == 23'h0) ? 23'h0 : mi_t - (ot_t % mi_t);
    wire [13:0] r_h   = 14'(r_t / mhc_pkg::MIN_PER_H);
    wire [5:0]  r_m   = 6'(r_t % mhc_pkg::MIN_PER_H);

    // minute prescaler
    mhc_if lnk ();
    assign lnk.run = en_s & ~prog;
    mhc_prescale #(.TICK_CYCLES(TICK_CYCLES)) u_pre (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .lnk   (lnk)
    );
    wire tick = lnk.tick;

    wire sat      = (ot_h == mhc_pkg::OT_H_MAX);
    wire rem_zero = (rem_h == 14'h0) & (rem_m == 6'h0);
    wire ot_inc   = tick & ~sat;

    // next values of the retained counters
    logic [13:0] next_rem_h;
    logic [5:0]  next_rem_m;
    logic [16:0] next_ot_h;
    logic [5:0]  next_ot_m;
    always_comb begin
        next_rem_h = rem_h;
        next_rem_m = rem_m;
        if (fr_rise | ir_rise) begin
            next_rem_h = eff_h;
            next_rem_m = eff_m;
        end else if (recalc) begin
            next_rem_h = r_h;
            next_rem_m = r_m;
        end else if (mi_chg & ~prog) begin
            next_rem_h = eff_h;
            next_rem_m = eff_m;
        end else if (tick & ~rem_zero) begin
            next_rem_h = (rem_m == 6'h0) ? rem_h - 14'h1 : rem_h;
            next_rem_m = (rem_m == 6'h0) ? mhc_pkg::MIN_MAX : rem_m - 6'h1;
        end
    end
    always_comb begin
        next_ot_h = ot_h;
        next_ot_m = ot_m;
        if (fr_rise) begin
            next_ot_h = 17'h0;
            next_ot_m = 6'h0;
        end else if (wr_ot) begin
            next_ot_h = (ot_wd[HL +: 17] > mhc_pkg::OT_H_MAX) ? mhc_pkg::OT_H_MAX
                                                              : ot_wd[HL +: 17];
            next_ot_m = clamp_m(ot_wd[MW-1:0]);
        end else if (ot_inc) begin
            next_ot_h = (ot_m == mhc_pkg::MIN_MAX) ? ot_h + 17'h1 : ot_h;
            next_ot_m = (ot_m == mhc_pkg::MIN_MAX) ? 6'h0 : ot_m + 6'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        rem_h   <= next_rem_h;
        rem_m   <= next_rem_m;
        ot_h    <= next_ot_h;
        ot_m    <= next_ot_m;
        mi_seen <= eff_mi;
        if (wr_mi) begin
            mi_h <= (mi_wd[HL +: 14] > mhc_pkg::MI_H_MAX) ? mhc_pkg::MI_H_MAX
                                                          : mi_wd[HL +: 14];
            mi_m <= clamp_m(mi_wd[MW-1:0]);
        end
    end

    // alarm: resets, and in idle mode a low enable, force it low
    wire alarm_clr  = ir_s | fr_s | (idle_clr & ~en_s);
    wire next_alarm = alarm_clr ? 1'b0 : (rem_zero | alarm);
    wire alarm_ev   = next_alarm & ~alarm;
    wire sat_ev     = ot_inc & (next_ot_h == mhc_pkg::OT_H_MAX) & ~sat;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl     <= mhc_pkg::CTRL_RESET;
            irq_st   <= mhc_pkg::IRQ_RESET;
            irq_mask <= mhc_pkg::IRQ_RESET;
            recalc   <= 1'b0;
            alarm    <= 1'b0;
        end else begin
            if (wr_ct) begin
                ctrl <= ct_wd[2:0];
            end
            if (wr_im) begin
                irq_mask <= im_wd[1:0];
            end
            // set wins over a write-one clear in the same cycle
            irq_st <= (irq_st & ~(wr_is ? is_wd[1:0] : 2'h0)) | {sat_ev, alarm_ev};
            recalc <= prog & (wr_ot | mi_chg);
            alarm  <= next_alarm;
        end
    end
    assign alarm_o = alarm;
    assign irq_o   = |(irq_st & irq_mask);

    // register read mux and wishbone answer
    wire [31:0] status = {29'h0, sat, en_s, alarm};
    wire [31:0] rdata  =
        (wb_adr_i == mhc_pkg::ADR_CTRL)     ? {29'h0, ctrl} :
        (wb_adr_i == mhc_pkg::ADR_INTERVAL) ? mi_rd :
        (wb_adr_i == mhc_pkg::ADR_REMAIN)   ? {10'h0, rem_h, 2'h0, rem_m} :
        (wb_adr_i == mhc_pkg::ADR_OPTIME)   ? ot_rd :
        (wb_adr_i == mhc_pkg::ADR_STATUS)   ? status :
        (wb_adr_i == mhc_pkg::ADR_IRQ_ST)   ? {30'h0, irq_st} :
        (wb_adr_i == mhc_pkg::ADR_IRQ_MASK) ? {30'h0, irq_mask} : 32'h0;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_q    <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            ack_q <= req & ~ack_q;
            if (req & ~ack_q) begin
                wb_dat_o <= rdata;
            end
        end
    end
    assign wb_ack_o = ack_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ivl_reload_a: assert property (ir_rise && !fr_rise |=>
        {rem_h, rem_m} == $past(eff_mi) && !alarm_o) else $error("interval reset reload wrong");
    full_clear_a: assert property (fr_rise |=>
        ot_h == 17'h0 && ot_m == 6'h0 && {rem_h, rem_m} == $past(eff_mi) && !alarm_o)
        else $error("full reset did not clear");
    idle_hold_a: assert property (!en_s && !fr_rise && !wr_ot |=> $stable({ot_h, ot_m}))
        else $error("time counted while idle");
    alarm_set_a: assert property (rem_zero && !alarm_clr |=> alarm_o)
        else $error("alarm missing at zero");
    rst_hold_a: assert property ((ir_s || fr_s) [*2] |-> !alarm_o)
        else $error("alarm high during reset");
    idle_clear_a: assert property (idle_clr && !en_s |=> !alarm_o)
        else $error("alarm high while idle");
    keep_only_a: assert property (!idle_clr && !ir_s && !fr_s && alarm_o |=> alarm_o)
        else $error("alarm cleared without reset");
    ot_limit_a: assert property (ot_h <= mhc_pkg::OT_H_MAX)
        else $error("operating time over limit");
    mi_limit_a: assert property (mi_h <= mhc_pkg::MI_H_MAX && mi_m <= mhc_pkg::MIN_MAX)
        else $error("interval out of range");
    ot_keep_a: assert property (ir_rise && !fr_rise && !tick && !wr_ot |=>
        $stable({ot_h, ot_m})) else $error("interval reset touched operating time");
    ot_count_a: assert property (tick && !sat && !fr_rise && !wr_ot && ot_m != 6'h3b |=>
        ot_m == $past(ot_m) + 6'h1) else $error("minute not counted");
    preset_a: assert property (recalc && !fr_rise && !ir_rise |=>
        {rem_h, rem_m} == $past({r_h, r_m})) else $error("preset remainder wrong");
    run_ivl_a: assert property (mi_chg && !prog && !fr_rise && !ir_rise && !recalc |=>
        {rem_h, rem_m} == $past(eff_mi)) else $error("interval change not taken");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    ack_resp_a: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    rem_floor_a: assert property (rem_zero && !fr_rise && !ir_rise &&
        !recalc && !mi_chg |=> rem_zero) else $error("remaining left zero");
    prog_hold_a: assert property (prog && !fr_rise && !wr_ot |=> $stable({ot_h, ot_m}))
        else $error("time counted in programming mode");
    sat_stop_a: assert property (sat && !fr_rise && !wr_ot |=> $stable({ot_h, ot_m}))
        else $error("operating time passed its limit");
    run_lock_a: assert property (wr && wb_adr_i == mhc_pkg::ADR_OPTIME && !prog &&
        !fr_rise && !tick |=> $stable({ot_h, ot_m})) else $error("preset taken in run mode");
    sat_irq_a: assert property (sat_ev |=> irq_st[mhc_pkg::IRQ_SAT])
        else $error("saturation event lost");
    alarm_irq_a: assert property (alarm_ev |=> irq_st[mhc_pkg::IRQ_ALARM])
        else $error("alarm event lost");
    rem_count_a: assert property (tick && !rem_zero && rem_m != 6'h0 && !fr_rise &&
        !ir_rise && !recalc && !mi_chg |=> rem_m == $past(rem_m) - 6'h1)
        else $error("remaining not counted down");
    ot_wrap_a: assert property (tick && !sat && !fr_rise && !wr_ot && ot_m == 6'h3b |=>
        ot_m == 6'h0 && ot_h == $past(ot_h) + 17'h1) else $error("hour carry wrong");
endmodule : mhc_counter

// *** mhc_field.sv ***
// far-side model: plant contacts and an hours-only interval source
`timescale 1ns/1ps
module mhc_field (
    input  wire logic        clk_i,
    input  wire logic        run_i,
    input  wire logic        rst_cmd_i,
    input  wire logic        all_cmd_i,
    input  wire logic [13:0] hours_i,
    output logic             enable_o,
    output logic             interval_reset_o,
    output logic             full_reset_o,
    output logic [13:0]      ext_interval_h_o
);
    initial begin
        enable_o = 1'b0;
        interval_reset_o = 1'b0;
        full_reset_o = 1'b0;
        ext_interval_h_o = 14'h0000;
    end
    // contacts change just after the scan edge, like a real input card
    always @(posedge clk_i) begin
        enable_o <= run_i;
        interval_reset_o <= rst_cmd_i;
        full_reset_o <= all_cmd_i;
        ext_interval_h_o <= hours_i;
    end
endmodule : mhc_field

// *** mhc_if.sv ***
// link between the counter core and its minute prescaler
`timescale 1ns/1ps
interface mhc_if;
    logic run;
    logic tick;
    modport core (output run, input tick);
    modport pre  (input run, output tick);
endinterface : mhc_if

// *** mhc_pkg.sv ***
// shared constants for the maintenance hours counter
package mhc_pkg;
    // register byte offsets
    localparam logic [7:0] ADR_CTRL     = 8'h00;
    localparam logic [7:0] ADR_INTERVAL = 8'h04;
    localparam logic [7:0] ADR_REMAIN   = 8'h08;
    localparam logic [7:0] ADR_OPTIME   = 8'h0c;
    localparam logic [7:0] ADR_STATUS   = 8'h10;
    localparam logic [7:0] ADR_IRQ_ST   = 8'h14;
    localparam logic [7:0] ADR_IRQ_MASK = 8'h18;
    // control bits
    localparam int CTRL_IDLE_CLR = 0;
    localparam int CTRL_PROG     = 1;
    localparam int CTRL_EXT_SEL  = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    // status and interrupt bits
    localparam int ST_ALARM = 0;
    localparam int ST_EN    = 1;
    localparam int ST_SAT   = 2;
    localparam int IRQ_ALARM = 0;
    localparam int IRQ_SAT   = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    // time field layout: minutes low, hours from bit 8
    localparam int MIN_LSB  = 0;
    localparam int HOUR_LSB = 8;
    localparam int MIN_W    = 6;
    localparam int MI_H_W   = 14;
    localparam int OT_H_W   = 17;
    localparam int TOT_W    = 23;
    localparam logic [5:0]  MIN_MAX  = 6'h3b;
    localparam logic [13:0] MI_H_MAX = 14'h270f;
    localparam logic [16:0] OT_H_MAX = 17'h1869f;
    localparam logic [22:0] MIN_PER_H = 23'h00003c;
    // one minute of counting at the scan clock
    localparam longint CLK_HZ   = 20000000;
    localparam longint MINUTE_S = 60;
    localparam int unsigned MINUTE_CYCLES = 32'(CLK_HZ * MINUTE_S);
endpackage : mhc_pkg

// *** mhc_prescale.sv ***
// sub-minute prescaler, advances only while counting is enabled
`timescale 1ns/1ps
module mhc_prescale #(
    parameter int unsigned TICK_CYCLES = mhc_pkg::MINUTE_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    mhc_if.pre        lnk
);
    logic [31:0] cnt;
    wire         last = (cnt == 32'(TICK_CYCLES - 1));

    // partial minutes are kept while the monitored input is low
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= 32'h0;
        end else if (lnk.run) begin
            cnt <= last ? 32'h0 : cnt + 32'h1;
        end
    end

    assign lnk.tick = lnk.run & last;
endmodule : mhc_prescale
